// ===== include/clk_ctrl_pkg.sv
// What this block does
// - Gate bit 13 set clocks the I/O port input logic; clear stops it.
// - Gate bit 12 set clocks the external memory port; clear stops it.
// - Gate bit 11 set clocks the DMA unit; clear stops it.
// - Gate bit 10 set clocks CPU timer 2; clear stops it.
// - Gate bit 9 set clocks CPU timer 1; clear stops it.
// - Gate bit 8 set clocks CPU timer 0; clear stops it.
// - Fast peripheral clock period is system clock times (N+1)*2.
// - Prescale field zero stops the fast clock; output holds a constant level.
// - Fast clock paces conversion-start ticks and the external converter clock.
// - After reset the prescaler is all ones and the converter clock runs.
// - Protected registers change only while the write window is open.
package clk_ctrl_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] GATE_OFFSET = 12'h000;
   localparam logic [ADDR_W-1:0] PRESCALE_OFFSET = 12'h004;
   localparam logic [ADDR_W-1:0] WINDOW_OFFSET = 12'h008;
   localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h00c;

   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int IO_PORT_BIT = 13;
   localparam int EXT_MEMORY_BIT = 12;
   localparam int DMA_BIT = 11;
   localparam int TIMER_TWO_BIT = 10;
   localparam int TIMER_ONE_BIT = 9;
   localparam int TIMER_ZERO_BIT = 8;
   localparam logic [15:0] GATE_WRITE_MASK = 16'h3f00;
   localparam logic [15:0] GATE_RESET = 16'h2700;
   localparam int PRESCALE_FIELD_W = 5;
   localparam logic [PRESCALE_FIELD_W-1:0] PRESCALE_RESET = 5'h1f;
   localparam int WINDOW_OPEN_BIT = 0;
   localparam int STATUS_BLOCKED_BIT = 0;
   localparam int STATUS_RUNNING_BIT = 1;
   localparam int STATUS_LEVEL_BIT = 2;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic io_port_input_clock_gate;
      logic ext_memory_port_clock_gate;
      logic direct_memory_access_clock_gate;
      logic timer_two_clock_gate;
      logic timer_one_clock_gate;
      logic timer_zero_clock_gate;
   } clock_gates_s;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ANSWER = 2'b01
   } bus_state_e;

endpackage

// ===== rtl/fast_clock_divider.sv
`timescale 1ns/1ns
module fast_clock_divider #(
   parameter int DIV_W = clk_ctrl_pkg::PRESCALE_FIELD_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [DIV_W-1:0] divisor,
   output logic fast_clk_q,
   output logic fast_rise_q,
   output logic running
);
   import clk_ctrl_pkg::*;

   logic [DIV_W-1:0] active_q;
   logic [DIV_W-1:0] cnt_q;

   if (DIV_W < 1 || DIV_W > 16) begin : g_bad_width
      $error("fast_clock_divider: divisor width must be 1 to 16");
   end

   assign running = (active_q != '0);

   // ----------------------------------------------------------------
   // Divider
   // ----------------------------------------------------------------
   // A new divisor is adopted at the end of a whole period, or at once while stopped, so a
   // change never shortens a half period into a runt pulse.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_q <= '1;
         cnt_q <= '0;
         fast_clk_q <= 1'b0;
      end else if (active_q == '0) begin
         cnt_q <= '0;
         fast_clk_q <= 1'b0;
         active_q <= divisor;
      end else if (cnt_q == active_q) begin
         cnt_q <= '0;
         fast_clk_q <= ~fast_clk_q;
         if (fast_clk_q) begin
            active_q <= divisor;
         end
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fast_rise_q <= 1'b0;
      end else begin
         fast_rise_q <= running && (cnt_q == active_q) && !fast_clk_q;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_HALF_PERIOD: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(fast_clk_q) && $past(active_q) != '0 |-> $past(cnt_q) == $past(active_q))
      else $error("fast clock toggled before its half period ended");
   AST_STOPPED_LOW: assert property (@(posedge pclk) disable iff (!presetn)
      active_q == '0 |=> !fast_clk_q)
      else $error("fast clock moved while the prescaler is zero");
   AST_DIVISOR_AT_BOUNDARY: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(active_q) |-> $past(active_q) == '0 || ($past(fast_clk_q) && !fast_clk_q))
      else $error("divisor adopted in mid period");
endmodule

// ===== rtl/periph_clock_gate_hs_prescaler.sv
`timescale 1ns/1ns
module periph_clock_gate_hs_prescaler #(
   parameter int PRESCALE_W = clk_ctrl_pkg::PRESCALE_FIELD_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [clk_ctrl_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output clk_ctrl_pkg::clock_gates_s unit_clock_gates,
   output logic fast_peripheral_clock,
   output logic conversion_start_tick,
   output logic external_converter_clock
);
   import clk_ctrl_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------
   if (PRESCALE_W != PRESCALE_FIELD_W) begin : g_bad_prescale
      $error("prescale width must match the documented 5-bit field");
   end

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   bus_state_e state_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [15:0] gate_q;
   logic [PRESCALE_W-1:0] prescale_q;
   logic window_q;
   logic blocked_q;
   logic ext_clk_q;
   logic fast_clk;
   logic fast_rise;
   logic running;
   logic access;
   logic commit;
   logic wr_commit;
   logic mapped;
   logic protected_hit;
   logic [31:0] read_value;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic logic hits(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] offset);
      hits = (addr == offset);
   endfunction

   assign access = psel && penable;
   assign mapped = hits(paddr, GATE_OFFSET) || hits(paddr, PRESCALE_OFFSET)
                   || hits(paddr, WINDOW_OFFSET) || hits(paddr, STATUS_OFFSET);
   assign protected_hit = hits(paddr, GATE_OFFSET) || hits(paddr, PRESCALE_OFFSET);
   assign commit = (state_q == BUS_ANSWER) && access && pready_q;
   assign wr_commit = commit && pwrite && !pslverr_q;

   always_comb begin
      read_value = 32'h0000_0000;
      if (hits(paddr, GATE_OFFSET)) begin
         read_value[15:0] = gate_q & GATE_WRITE_MASK;
      end else if (hits(paddr, PRESCALE_OFFSET)) begin
         read_value[PRESCALE_W-1:0] = prescale_q;
      end else if (hits(paddr, WINDOW_OFFSET)) begin
         read_value[WINDOW_OPEN_BIT] = window_q;
      end else if (hits(paddr, STATUS_OFFSET)) begin
         read_value[STATUS_BLOCKED_BIT] = blocked_q;
         read_value[STATUS_RUNNING_BIT] = running;
         read_value[STATUS_LEVEL_BIT] = fast_clk;
      end
   end

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   // One wait state: the answer is built from a flop so that prdata,
   // pready and pslverr all come straight from registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= BUS_IDLE;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         case (state_q)
            BUS_IDLE: begin
               if (access) begin
                  state_q <= BUS_ANSWER;
                  pready_q <= 1'b1;
                  pslverr_q <= !mapped;
                  prdata_q <= pwrite ? 32'h0000_0000 : read_value;
               end
            end
            BUS_ANSWER: begin
               state_q <= BUS_IDLE;
               pready_q <= 1'b0;
               pslverr_q <= 1'b0;
               prdata_q <= 32'h0000_0000;
            end
            default: begin
               state_q <= BUS_IDLE;
               pready_q <= 1'b0;
               pslverr_q <= 1'b0;
               prdata_q <= 32'h0000_0000;
            end
         endcase
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   // ----------------------------------------------------------------
   // Write window
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         window_q <= 1'b0;
      end else if (wr_commit && hits(paddr, WINDOW_OFFSET)) begin
         window_q <= pwdata[WINDOW_OPEN_BIT];
      end
   end

   // A refused write is otherwise silent, so software can find it here.
   // A new refusal in the clearing cycle wins over the clear.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blocked_q <= 1'b0;
      end else if (wr_commit && protected_hit && !window_q) begin
         blocked_q <= 1'b1;
      end else if (wr_commit && hits(paddr, STATUS_OFFSET) && pwdata[STATUS_BLOCKED_BIT]) begin
         blocked_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Gating register
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_q <= GATE_RESET;
      end else if (wr_commit && hits(paddr, GATE_OFFSET) && window_q) begin
         gate_q <= pwdata[15:0] & GATE_WRITE_MASK;
      end
   end

   // Each unit gets a registered enable, so its clock gate never sees a
   // bus glitch; the enable changes only on a system clock edge.
   assign unit_clock_gates.io_port_input_clock_gate = gate_q[IO_PORT_BIT];
   assign unit_clock_gates.ext_memory_port_clock_gate = gate_q[EXT_MEMORY_BIT];
   assign unit_clock_gates.direct_memory_access_clock_gate = gate_q[DMA_BIT];
   assign unit_clock_gates.timer_two_clock_gate = gate_q[TIMER_TWO_BIT];
   assign unit_clock_gates.timer_one_clock_gate = gate_q[TIMER_ONE_BIT];
   assign unit_clock_gates.timer_zero_clock_gate = gate_q[TIMER_ZERO_BIT];

   // ----------------------------------------------------------------
   // Prescale register
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescale_q <= PRESCALE_RESET;
      end else if (wr_commit && hits(paddr, PRESCALE_OFFSET) && window_q) begin
         prescale_q <= pwdata[PRESCALE_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Fast peripheral clock
   // ----------------------------------------------------------------
   fast_clock_divider #(
      .DIV_W(PRESCALE_W)
   ) u_divider (
      .pclk(pclk),
      .presetn(presetn),
      .divisor(prescale_q),
      .fast_clk_q(fast_clk),
      .fast_rise_q(fast_rise),
      .running(running)
   );

   // The pad copy lags the internal clock by one cycle; both share the
   // same divider so their periods always agree.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_clk_q <= 1'b0;
      end else begin
         ext_clk_q <= fast_clk;
      end
   end

   assign fast_peripheral_clock = fast_clk;
   assign conversion_start_tick = fast_rise;
   assign external_converter_clock = ext_clk_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence open_gate_write;
      wr_commit && hits(paddr, GATE_OFFSET) && window_q;
   endsequence

   sequence closed_protected_write;
      wr_commit && protected_hit && !window_q;
   endsequence

   AST_IO_PORT_GATE: assert property (@(posedge pclk) disable iff (!presetn)
      open_gate_write |=> unit_clock_gates.io_port_input_clock_gate == $past(pwdata[IO_PORT_BIT]))
      else $error("I/O port input gate did not follow the write");
   AST_EXT_MEMORY_GATE: assert property (@(posedge pclk) disable iff (!presetn)
      open_gate_write |=> unit_clock_gates.ext_memory_port_clock_gate == $past(pwdata[EXT_MEMORY_BIT]))
      else $error("external memory port gate did not follow the write");
   AST_DMA_GATE: assert property (@(posedge pclk) disable iff (!presetn)
      open_gate_write |=> unit_clock_gates.direct_memory_access_clock_gate == $past(pwdata[DMA_BIT]))
      else $error("DMA gate did not follow the write");
   AST_TIMER_TWO_GATE: assert property (@(posedge pclk) disable iff (!presetn)
      open_gate_write |=> unit_clock_gates.timer_two_clock_gate == $past(pwdata[TIMER_TWO_BIT]))
      else $error("timer 2 gate did not follow the write");
   AST_TIMER_ONE_GATE: assert property (@(posedge pclk) disable iff (!presetn)
      open_gate_write |=> unit_clock_gates.timer_one_clock_gate == $past(pwdata[TIMER_ONE_BIT]))
      else $error("timer 1 gate did not follow the write");
   AST_TIMER_ZERO_GATE: assert property (@(posedge pclk) disable iff (!presetn)
      open_gate_write |=> unit_clock_gates.timer_zero_clock_gate == $past(pwdata[TIMER_ZERO_BIT]))
      else $error("timer 0 gate did not follow the write");

   AST_PERIOD_ONE: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(fast_clk) && u_divider.active_q == 5'h01
      |-> !fast_clk [*2] ##1 fast_clk [*2] ##1 !fast_clk)
      else $error("prescale 1 did not give divide by 4");
   AST_ZERO_CONSTANT: assert property (@(posedge pclk) disable iff (!presetn)
      u_divider.active_q == '0 && prescale_q == '0 |=> !fast_clk [*3])
      else $error("fast clock ran with a zero prescale");
   AST_TICK_ON_RISE: assert property (@(posedge pclk) disable iff (!presetn)
      conversion_start_tick |-> $rose(fast_clk) ##1 external_converter_clock)
      else $error("conversion tick not aligned to the fast clock rise");
   AST_RUNS_AFTER_RESET: assert property (@(posedge pclk)
      $rose(presetn) |-> prescale_q == PRESCALE_RESET ##32 fast_clk)
      else $error("converter clock not running after reset");
   AST_CLOSED_WINDOW: assert property (@(posedge pclk) disable iff (!presetn)
      closed_protected_write |=> $stable(gate_q) && $stable(prescale_q) && blocked_q)
      else $error("protected register changed with the window closed");
   AST_RESERVED_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      pready_q && !pslverr_q && hits(paddr, GATE_OFFSET) |-> (prdata_q & ~{16'h0000, GATE_WRITE_MASK}) == 32'h0)
      else $error("reserved gate bits did not read as zero");
   AST_ONE_WAIT_STATE: assert property (@(posedge pclk) disable iff (!presetn)
      state_q == BUS_IDLE && access |=> pready_q ##1 !pready_q)
      else $error("bus answer not given after exactly one wait state");

   // ----------------------------------------------------------------
   // Register, bus and clock output checks
   // ----------------------------------------------------------------
   // These cover the register side and the clock outputs, so a stray write path or
   // a broken decode fires here even where the bench never reads back.
   sequence unmapped_access;
      state_q == BUS_IDLE && access && !mapped;
   endsequence

   sequence open_prescale_write;
      wr_commit && hits(paddr, PRESCALE_OFFSET) && window_q;
   endsequence

   sequence window_write;
      wr_commit && hits(paddr, WINDOW_OFFSET);
   endsequence

   sequence gate_read;
      state_q == BUS_IDLE && access && !pwrite && hits(paddr, GATE_OFFSET);
   endsequence

   sequence prescale_read;
      state_q == BUS_IDLE && access && !pwrite && hits(paddr, PRESCALE_OFFSET);
   endsequence

   AST_UNMAPPED_ERROR: assert property (unmapped_access
      |=> pready_q && pslverr_q && prdata_q == 32'h0000_0000)
      else $error("unmapped access not answered with an error");

   AST_UNMAPPED_NO_EFFECT: assert property (commit && !mapped
      |=> $stable(gate_q) && $stable(prescale_q) && $stable(window_q))
      else $error("unmapped write changed a register");

   AST_PRESCALE_WRITE: assert property (open_prescale_write
      |=> prescale_q == $past(pwdata[PRESCALE_W-1:0]))
      else $error("prescale did not take an open window write");

   AST_PRESCALE_HOLDS: assert property (!(wr_commit && hits(paddr, PRESCALE_OFFSET))
      |=> $stable(prescale_q))
      else $error("prescale changed without a write");

   AST_GATE_HOLDS: assert property (!(wr_commit && hits(paddr, GATE_OFFSET))
      |=> $stable(gate_q))
      else $error("gate register changed without a write");

   AST_GATE_RESERVED: assert property (
      (gate_q & ~GATE_WRITE_MASK) == 16'h0000)
      else $error("reserved gate bits were set");

   AST_WINDOW_FOLLOWS: assert property (window_write
      |=> window_q == $past(pwdata[WINDOW_OPEN_BIT]))
      else $error("write window did not follow the write");

   AST_BLOCKED_CLEAR: assert property (wr_commit && hits(paddr, STATUS_OFFSET) && pwdata[STATUS_BLOCKED_BIT]
      |=> !blocked_q)
      else $error("blocked flag not cleared");

   AST_BLOCKED_STICKY: assert property (blocked_q && !(wr_commit && hits(paddr, STATUS_OFFSET))
      |=> blocked_q)
      else $error("blocked flag lost without a clear");

   AST_READ_GATE: assert property (gate_read
      |=> prdata_q[15:0] == $past(gate_q) && prdata_q[31:16] == 16'h0000)
      else $error("gate read returned a wrong value");

   AST_READ_PRESCALE: assert property (prescale_read
      |=> prdata_q[PRESCALE_W-1:0] == $past(prescale_q) && prdata_q[31:PRESCALE_W] == '0)
      else $error("prescale read returned a wrong value");

   AST_READY_PULSE: assert property (pready_q
      |=> !pready_q)
      else $error("pready stood for more than one cycle");

   AST_ERR_WITH_READY: assert property (pslverr_q
      |-> pready_q)
      else $error("pslverr without pready");

   AST_RDATA_IDLE: assert property (!pready_q
      |-> prdata_q == 32'h0000_0000)
      else $error("read data shown outside an answer");

   AST_WRITE_NO_DATA: assert property (pready_q && pwrite
      |-> prdata_q == 32'h0000_0000)
      else $error("read data shown on a write");

   AST_EXT_FOLLOWS: assert property (
      external_converter_clock == $past(fast_peripheral_clock))
      else $error("converter clock does not trail the fast clock");

   AST_TICK_ONE_CYCLE: assert property (conversion_start_tick
      |=> !conversion_start_tick)
      else $error("conversion tick stood for more than one cycle");

   AST_NO_TICK_STOPPED: assert property (!running
      |=> !conversion_start_tick)
      else $error("conversion tick while the divider is stopped");

   AST_RESET_STATE: assert property ($rose(presetn)
      |-> gate_q == GATE_RESET && prescale_q == PRESCALE_RESET && !window_q && !blocked_q)
      else $error("registers not at their reset values");
endmodule

// ===== testbench/periph_clock_gate_hs_prescaler_bench.sv
`timescale 1ns/1ns
module periph_clock_gate_hs_prescaler_bench;
   import clk_ctrl_pkg::*;

   // ----------------------------------------------------------------
   // Stimulus and design
   // ----------------------------------------------------------------
   logic pclk = 1'b0;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   clock_gates_s unit_clock_gates;
   logic fast_peripheral_clock;
   logic conversion_start_tick;
   logic external_converter_clock;
   logic mon_en;
   logic fast_prev;
   int bad_count = 0;
   int checks = 0;
   int cycles = 0;

   always #5 pclk = ~pclk;

   periph_clock_gate_hs_prescaler periph_clock_gate_hs_prescaler_inst (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .unit_clock_gates(unit_clock_gates),
      .fast_peripheral_clock(fast_peripheral_clock),
      .conversion_start_tick(conversion_start_tick),
      .external_converter_clock(external_converter_clock)
   );

   // ----------------------------------------------------------------
   // Checking and closing
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // The longest scenario is a few divide-by-64 periods, so this ceiling is generous.
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 30000) begin
         bad_count++;
         stop_test();
      end
   end

   // The converter clock trails the fast clock by one cycle and the tick marks each rise.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fast_prev <= 1'b0;
      end else if (mon_en) begin
         chk("ext_clock", {31'h0, external_converter_clock}, {31'h0, fast_prev});
         chk("start_tick", {31'h0, conversion_start_tick}, {31'h0, fast_peripheral_clock & ~fast_prev});
         fast_prev <= fast_peripheral_clock;
      end
   end

   // ----------------------------------------------------------------
   // Bus tasks
   // ----------------------------------------------------------------
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] rd, input logic err_exp);
      int n;
      n = 0;
      rd = 32'h0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         bad_count++;
         $display("[ERR] pready expected 1 seen %b", pready);
      end
      rd = prdata;
      chk("pslverr", {31'h0, pslverr}, {31'h0, err_exp});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      logic [31:0] unused;
      apb(1'b1, a, d, unused, 1'b0);
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v);
      apb(1'b0, a, 32'h0, v, 1'b0);
   endtask

   // Measures one full fast clock period, from tick to tick, and its high time.
   task automatic period(output int p, output int h);
      int n;
      n = 0;
      p = 0;
      h = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (conversion_start_tick !== 1'b1 && n < 300);
      do begin
         @(posedge pclk);
         p++;
         if (fast_peripheral_clock === 1'b1) h++;
      end while (conversion_start_tick !== 1'b1 && p < 300);
   endtask

   function automatic int exp_period(input int n);
      return 2 * (n + 1);
   endfunction

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] v;
      logic [31:0] d;
      int p;
      int h;
      int n;
      int toggles;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h0;
      presetn = 1'b0;
      mon_en = 1'b0;
      void'($urandom(32'h5ed4e98a));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      mon_en <= 1'b1;
      rd(GATE_OFFSET, v);
      chk("gate_reset", v, 32'h2700);
      chk("gates_out_reset", {26'h0, unit_clock_gates}, 32'h27);
      rd(PRESCALE_OFFSET, v);
      chk("prescale_reset", v, 32'h1f);
      period(p, h);
      chk("period_reset", p, 64);
      chk("high_reset", h, 32);
      // Writes with the window still closed must leave both registers alone.
      wr(GATE_OFFSET, 32'h3f00);
      wr(PRESCALE_OFFSET, 32'h3);
      rd(GATE_OFFSET, v);
      chk("gate_locked", v, 32'h2700);
      rd(PRESCALE_OFFSET, v);
      chk("prescale_locked", v, 32'h1f);
      rd(STATUS_OFFSET, v);
      chk("blocked_flag", {31'h0, v[STATUS_BLOCKED_BIT]}, 32'h1);
      wr(STATUS_OFFSET, 32'h1);
      rd(STATUS_OFFSET, v);
      chk("blocked_clear", {31'h0, v[STATUS_BLOCKED_BIT]}, 32'h0);
      wr(WINDOW_OFFSET, 32'h1);
      // Walk a single enable through each gate bit, then random patterns.
      for (int i = 0; i < 10; i++) begin
         d = (i < 6) ? (32'h100 << i) : $urandom;
         wr(GATE_OFFSET, d);
         @(posedge pclk);
         chk("gates_out", {26'h0, unit_clock_gates}, {26'h0, d[13:8]});
         rd(GATE_OFFSET, v);
         chk("gate_read", v, d & 32'h3f00);
      end
      // A zero field stops the fast clock at a constant level.
      wr(PRESCALE_OFFSET, 32'hffffffe0);
      rd(PRESCALE_OFFSET, v);
      chk("prescale_zero", v, 32'h0);
      repeat (70) @(posedge pclk);
      toggles = 0;
      for (int i = 0; i < 40; i++) begin
         @(posedge pclk);
         if (fast_peripheral_clock !== 1'b0) toggles++;
      end
      chk("stopped_level", toggles, 0);
      rd(STATUS_OFFSET, v);
      chk("running_flag", {31'h0, v[STATUS_RUNNING_BIT]}, 32'h0);
      chk("stopped_read_level", {31'h0, v[STATUS_LEVEL_BIT]}, 32'h0);
      // Boundary divisors first, then random ones.
      for (int i = 0; i < 6; i++) begin
         n = (i == 0) ? 1 : (i == 1) ? 31 : $urandom_range(31, 1);
         d = $urandom;
         wr(PRESCALE_OFFSET, {d[31:5], n[4:0]});
         rd(PRESCALE_OFFSET, v);
         chk("prescale_read", v, n);
         period(p, h);
         period(p, h);
         chk("period", p, exp_period(n));
         chk("high_time", h, n + 1);
         rd(STATUS_OFFSET, v);
         chk("running_on", {31'h0, v[STATUS_RUNNING_BIT]}, 32'h1);
      end
      wr(WINDOW_OFFSET, 32'h0);
      wr(PRESCALE_OFFSET, 32'h5);
      rd(PRESCALE_OFFSET, v);
      chk("prescale_relocked", v, n);
      apb(1'b1, 12'h010, 32'hffffffff, v, 1'b1);
      apb(1'b0, 12'hffc, 32'h0, v, 1'b1);
      // A reset in mid-run restores the defaults and restarts the converter clock.
      @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("gates_out_rereset", {26'h0, unit_clock_gates}, 32'h27);
      period(p, h);
      chk("period_rereset", p, 64);
      stop_test();
   end
endmodule
